/* hw/integ_sync_params.svh */
// Offsets, field positions, reset values and timing counts of the
// integration and interrupt controller.
// Assumes a byte-wide register port from the serial-bus engine.
`ifndef INTEG_SYNC_PARAMS_SVH
`define INTEG_SYNC_PARAMS_SVH

`define OFS_CONTROL 5'h00
`define OFS_TIMING 5'h01
`define OFS_IRQ_CTRL 5'h02
`define OFS_IRQ_SEL 5'h03
`define OFS_THR_LO_L 5'h08
`define OFS_THR_LO_H 5'h09
`define OFS_THR_HI_L 5'h0A
`define OFS_THR_HI_H 5'h0B
`define OFS_DATA_BASE 5'h10

`define CTRL_POWER_BIT 0
`define CTRL_ADC_EN_BIT 1
`define TIM_INTEG_TIME_OR_PULSE_COUNT_LSB 0
`define TIM_MODE_LSB 4
`define TIM_EDGE_BIT 6
`define IRQ_PERSIST_LSB 0
`define IRQ_MODE_LSB 4
`define CMD_CLR_LSB 5
`define CMD_CLR_LEVEL 2'h3

`define RST_CONTROL 8'h00
`define RST_TIMING 8'h00
`define RST_IRQ_CTRL 8'h00
`define RST_IRQ_SEL 8'h00
`define RST_THRESH 16'h0000

`define CORE_CLK_MHZ 50
`define INTEG_SHORT_US 12000
`define INTEG_MID_US 100000
`define INTEG_LONG_US 400000

`endif

/* hw/integ_sync_pkg.sv */
// Types of the integration and interrupt controller.
// Enum encodings are set here; offsets, fields and timing counts come from the params header.
`default_nettype none
package integ_sync_pkg;

typedef enum logic [1:0] {
    INTEG_FREE = 2'h0,
    INTEG_MANUAL = 2'h1,
    INTEG_ONE_SHOT = 2'h2,
    INTEG_PULSES = 2'h3
} integration_mode_sel_type;

typedef enum logic [1:0] {
    IRQ_OFF = 2'h0,
    IRQ_LEVEL = 2'h1,
    IRQ_ALERT = 2'h2,
    IRQ_TEST = 2'h3
} irq_style_type;

typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_TIMED = 3'h1,
    ST_MANUAL = 3'h2,
    ST_WAIT_SYNC = 3'h3,
    ST_PULSE = 3'h4
} integ_state_type;

typedef struct packed {
    logic power;
    logic adc_en;
    logic [7:0] timing;
    logic [7:0] irq_ctrl;
    logic [1:0] irq_sel;
    logic [15:0] thr_lo;
    logic [15:0] thr_hi;
    logic [63:0] results;
    logic sy1;
    logic sy2;
    logic sy3;
    logic sy_lvl;
    integ_state_type state;
    logic [24:0] tmr;
    logic [3:0] edge_cnt;
    logic lock;
    logic eval;
    logic [2:0] pcnt;
    logic pending;
    logic integ;
    logic conv_done;
    logic irq_oe;
    logic alert_ack;
    logic [7:0] rdata;
} core_state_type;

typedef struct packed {
    logic sync_lvl;
} link_state_type;

endpackage
`default_nettype wire

/* hw/integ_sync_irq_ctrl.sv */
// Integration sequencer and threshold interrupt of a four-channel
// colour sensor. Assumes a serial-bus engine that hands over byte
// register accesses and command bytes, an ADC front end that integrates
// while integrating_o is high, and a sync source on its own clock.
//
// Contract
// [RL1] Timed mode: free-running or one-per-sync-trigger
// [RL2] Manual mode: enable bit starts and stops
// [RL3] Host disables, clears, configures before manual run
// [RL4] One-shot: sync rise starts one timed integration
// [RL5] Parameter selects 12, 100 or 400 ms
// [RL6] Pulse mode: first rise to selected edge
// [RL7] Rearm only after enable toggles low-high
// [RL8] Rising stop edge ends at pulse N+1
// [RL9] Falling stop edge ends at pulse N
// [RL10] Pulse mode integrates only while sync high
// [RL11] Sync pulses stay high at least 50 us
// [RL12] 0x21 one-shot 100 ms; 0x30 one pulse
// [RL13] Zero interrupt control disables interrupts
// [RL14] Two 16-bit thresholds flag out-of-range results
// [RL15] Channel select picks compared channel
// [RL16] Persistence filters transient excursions
// [RL17] Interrupt pin low until cleared
// [RL18] Level style cleared by command field 11b
// [RL19] Alert style cleared by alert response
// [RL20] Persistence zero interrupts every conversion
// [RL21] 0x10 level every cycle; 0x01 channel two
// [RL22] Control 03h powers up and converts
// [RL23] Interrupt mode 11 forces pin active
// [RL24] All results latched before threshold check
`timescale 1ns/100ps
`default_nettype none
`include "integ_sync_params.svh"

module integ_sync_irq_ctrl #(
    parameter int unsigned SHORT_CYC = `INTEG_SHORT_US * `CORE_CLK_MHZ,
    parameter int unsigned MID_CYC = `INTEG_MID_US * `CORE_CLK_MHZ,
    parameter int unsigned LONG_CYC = `INTEG_LONG_US * `CORE_CLK_MHZ
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic sync_clk_i,
    input wire logic sync_pin_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic cmd_wr_i,
    input wire logic [7:0] cmd_byte_i,
    input wire logic alert_resp_i,
    input wire logic [63:0] adc_data_i,
    output logic [7:0] reg_rdata_o,
    output logic integrating_o,
    output logic conv_done_o,
    output logic alert_ack_o,
    output logic irq_o,
    output logic irq_oe_o
);

    integ_sync_pkg::core_state_type q;
    integ_sync_pkg::core_state_type n;
    integ_sync_pkg::link_state_type lq;
    integ_sync_pkg::link_state_type ln;

    logic run_ok;
    logic rise;
    logic fall;
    logic new_lvl;
    logic [24:0] period_last;
    logic [3:0] integ_time_or_pulse_count;
    logic [2:0] persist;
    logic [15:0] sel_val;
    logic out_of_range;
    logic clr_level;
    integ_sync_pkg::integration_mode_sel_type mode;
    integ_sync_pkg::irq_style_type style;

    // Last cycle of an internally timed period
    function automatic logic [24:0] period_of(input logic [3:0] p);
        unique case (p)
            4'h0: period_of = 25'(SHORT_CYC - 1);
            4'h1: period_of = 25'(MID_CYC - 1);
            default: period_of = 25'(LONG_CYC - 1);
        endcase
    endfunction

    function automatic logic [15:0] chan_of(input logic [63:0] r,
                                            input logic [1:0] s);
        chan_of = r[{s, 4'h0} +: 16];
    endfunction

    // Sync pin sampled on its own clock; reset is synchronous to it too
    always_comb
    begin
        ln = lq;
        ln.sync_lvl = sync_pin_i;
        if (!nrst_i)
        begin
            ln.sync_lvl = 1'b0;
        end
    end

    always_ff @(posedge sync_clk_i)
    begin
        lq <= ln;
    end

    assign run_ok = q.power & q.adc_en;
    // [RL12] Timing fields decoded
    assign mode = integ_sync_pkg::integration_mode_sel_type'(
        q.timing[`TIM_MODE_LSB +: 2]);
    assign style = integ_sync_pkg::irq_style_type'(
        q.irq_ctrl[`IRQ_MODE_LSB +: 2]);
    assign integ_time_or_pulse_count = q.timing[`TIM_INTEG_TIME_OR_PULSE_COUNT_LSB +: 4];
    assign persist = q.irq_ctrl[`IRQ_PERSIST_LSB +: 3];
    assign period_last = period_of(integ_time_or_pulse_count);
    // A level change counts only once the second and third stages agree
    assign new_lvl = (q.sy2 == q.sy3) ? q.sy3 : q.sy_lvl;
    assign rise = new_lvl & ~q.sy_lvl;
    assign fall = ~new_lvl & q.sy_lvl;
    // [RL15] Selected channel value
    assign sel_val = chan_of(q.results, q.irq_sel);
    // [RL14] Outside either threshold
    assign out_of_range = (sel_val > q.thr_hi) || (sel_val < q.thr_lo);
    assign clr_level = cmd_wr_i
        && (cmd_byte_i[`CMD_CLR_LSB +: 2] == `CMD_CLR_LEVEL);

    always_comb
    begin
        n = q;
        n.conv_done = 1'b0;
        n.alert_ack = 1'b0;
        n.eval = 1'b0;
        n.sy1 = lq.sync_lvl;
        n.sy2 = q.sy1;
        n.sy3 = q.sy2;
        n.sy_lvl = new_lvl;

        if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                // [RL22] Power and enable bits
                `OFS_CONTROL:
                begin
                    n.power = reg_wdata_i[`CTRL_POWER_BIT];
                    n.adc_en = reg_wdata_i[`CTRL_ADC_EN_BIT];
                end
                `OFS_TIMING: n.timing = reg_wdata_i;
                // [RL21] Style and channel fields
                `OFS_IRQ_CTRL: n.irq_ctrl = reg_wdata_i;
                `OFS_IRQ_SEL: n.irq_sel = reg_wdata_i[1:0];
                `OFS_THR_LO_L: n.thr_lo[7:0] = reg_wdata_i;
                `OFS_THR_LO_H: n.thr_lo[15:8] = reg_wdata_i;
                `OFS_THR_HI_L: n.thr_hi[7:0] = reg_wdata_i;
                `OFS_THR_HI_H: n.thr_hi[15:8] = reg_wdata_i;
                default:
                begin
                end
            endcase
        end

        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                `OFS_CONTROL: n.rdata = {6'h00, q.adc_en, q.power};
                `OFS_TIMING: n.rdata = q.timing;
                `OFS_IRQ_CTRL: n.rdata = q.irq_ctrl;
                `OFS_IRQ_SEL: n.rdata = {6'h00, q.irq_sel};
                `OFS_THR_LO_L: n.rdata = q.thr_lo[7:0];
                `OFS_THR_LO_H: n.rdata = q.thr_lo[15:8];
                `OFS_THR_HI_L: n.rdata = q.thr_hi[7:0];
                `OFS_THR_HI_H: n.rdata = q.thr_hi[15:8];
                default:
                begin
                    if (reg_addr_i[4:3] == 2'(`OFS_DATA_BASE >> 3))
                    begin
                        n.rdata = q.results[{reg_addr_i[2:0], 3'h0} +: 8];
                    end
                    else
                    begin
                        n.rdata = 8'h00;
                    end
                end
            endcase
        end

        // [RL7] Lock releases only while enable is low
        if (!q.adc_en)
        begin
            n.lock = 1'b0;
        end

        unique case (q.state)
            integ_sync_pkg::ST_IDLE:
            begin
                n.tmr = 25'h0000000;
                n.edge_cnt = 4'h0;
                n.integ = 1'b0;
                if (run_ok && !q.lock)
                begin
                    unique case (mode)
                        // [RL1] Back-to-back timed conversions
                        integ_sync_pkg::INTEG_FREE:
                        begin
                            n.state = integ_sync_pkg::ST_TIMED;
                            n.integ = 1'b1;
                        end
                        // [RL2] Manual start on enable
                        integ_sync_pkg::INTEG_MANUAL:
                        begin
                            n.state = integ_sync_pkg::ST_MANUAL;
                            n.integ = 1'b1;
                        end
                        default: n.state = integ_sync_pkg::ST_WAIT_SYNC;
                    endcase
                end
            end
            integ_sync_pkg::ST_TIMED:
            begin
                n.tmr = q.tmr + 25'h0000001;
                if (!run_ok)
                begin
                    n.state = integ_sync_pkg::ST_IDLE;
                    n.integ = 1'b0;
                end
                // [RL5] Period from the parameter field
                else if (q.tmr == period_last)
                begin
                    n.state = integ_sync_pkg::ST_IDLE;
                    n.integ = 1'b0;
                    n.conv_done = 1'b1;
                    n.lock = (mode == integ_sync_pkg::INTEG_ONE_SHOT);
                end
            end
            integ_sync_pkg::ST_MANUAL:
            begin
                // [RL2] Manual stop on enable clear
                if (!run_ok)
                begin
                    n.state = integ_sync_pkg::ST_IDLE;
                    n.integ = 1'b0;
                    n.conv_done = q.power;
                end
            end
            integ_sync_pkg::ST_WAIT_SYNC:
            begin
                if (!run_ok)
                begin
                    n.state = integ_sync_pkg::ST_IDLE;
                end
                // [RL4] Sync rise starts one timed run
                else if (rise && mode == integ_sync_pkg::INTEG_ONE_SHOT)
                begin
                    n.state = integ_sync_pkg::ST_TIMED;
                    n.integ = 1'b1;
                end
                // [RL6] First rise opens pulse window
                else if (rise && mode == integ_sync_pkg::INTEG_PULSES)
                begin
                    n.state = integ_sync_pkg::ST_PULSE;
                    n.integ = 1'b1;
                end
                else if (mode == integ_sync_pkg::INTEG_FREE
                    || mode == integ_sync_pkg::INTEG_MANUAL)
                begin
                    n.state = integ_sync_pkg::ST_IDLE;
                end
            end
            integ_sync_pkg::ST_PULSE:
            begin
                // [RL10] Light gathered only while sync high
                n.integ = new_lvl;
                if (!run_ok)
                begin
                    n.state = integ_sync_pkg::ST_IDLE;
                    n.integ = 1'b0;
                end
                // [RL8] Rising edge of pulse N+1 ends
                else if (q.timing[`TIM_EDGE_BIT] && rise)
                begin
                    if (q.edge_cnt == integ_time_or_pulse_count)
                    begin
                        n.state = integ_sync_pkg::ST_IDLE;
                        n.integ = 1'b0;
                        n.conv_done = 1'b1;
                        n.lock = 1'b1;
                    end
                    else
                    begin
                        n.edge_cnt = q.edge_cnt + 4'h1;
                    end
                end
                // [RL9] Falling edge of pulse N ends
                else if (!q.timing[`TIM_EDGE_BIT] && fall)
                begin
                    if (q.edge_cnt == integ_time_or_pulse_count)
                    begin
                        n.state = integ_sync_pkg::ST_IDLE;
                        n.integ = 1'b0;
                        n.conv_done = 1'b1;
                        n.lock = 1'b1;
                    end
                    else
                    begin
                        n.edge_cnt = q.edge_cnt + 4'h1;
                    end
                end
            end
            default:
            begin
                n.state = integ_sync_pkg::ST_IDLE;
                n.integ = 1'b0;
            end
        endcase

        // [RL24] Latch all channels, evaluate next cycle
        if (n.conv_done)
        begin
            n.results = adc_data_i;
            n.eval = 1'b1;
        end

        // Clears come first so that a same-cycle event wins
        if (style == integ_sync_pkg::IRQ_LEVEL && clr_level)
        begin
            // [RL18] Command clear for level style
            n.pending = 1'b0;
        end
        if (style == integ_sync_pkg::IRQ_ALERT && alert_resp_i && q.pending)
        begin
            // [RL19] Alert response answered and cleared
            n.pending = 1'b0;
            n.alert_ack = 1'b1;
        end

        if (q.eval)
        begin
            if (persist == 3'h0)
            begin
                // [RL20] Every conversion raises the interrupt
                n.pending = 1'b1;
            end
            else if (out_of_range)
            begin
                // [RL16] Consecutive excursions counted
                if (4'(q.pcnt) + 4'h1 >= 4'(persist))
                begin
                    n.pending = 1'b1;
                end
                if (q.pcnt != 3'h7)
                begin
                    n.pcnt = q.pcnt + 3'h1;
                end
            end
            else
            begin
                n.pcnt = 3'h0;
            end
        end

        // [RL13] Disabled style drops any pending event
        if (style == integ_sync_pkg::IRQ_OFF)
        begin
            n.pending = 1'b0;
            n.pcnt = 3'h0;
        end

        // [RL17] Pin held low while pending; [RL23] test forces it
        n.irq_oe = n.pending
            || (n.irq_ctrl[`IRQ_MODE_LSB +: 2] == integ_sync_pkg::IRQ_TEST);

        if (!nrst_i)
        begin
            n = '0;
            n.timing = `RST_TIMING;
            n.irq_ctrl = `RST_IRQ_CTRL;
            n.irq_sel = 2'(`RST_IRQ_SEL);
            n.thr_lo = `RST_THRESH;
            n.thr_hi = `RST_THRESH;
            n.power = 1'(`RST_CONTROL >> `CTRL_POWER_BIT);
            n.adc_en = 1'(`RST_CONTROL >> `CTRL_ADC_EN_BIT);
            n.state = integ_sync_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        q <= n;
    end

    assign reg_rdata_o = q.rdata;
    assign integrating_o = q.integ;
    assign conv_done_o = q.conv_done;
    assign alert_ack_o = q.alert_ack;
    // Open-drain pin: only ever drives low
    assign irq_o = 1'b0;
    assign irq_oe_o = q.irq_oe;

    property p_manual_start;
        @(posedge core_clk_i) disable iff (!nrst_i)
        q.state == integ_sync_pkg::ST_IDLE && run_ok && !q.lock
            && mode == integ_sync_pkg::INTEG_MANUAL |=> integrating_o;
    endproperty
    a_manual_start: assert property (p_manual_start) // [RL2]
        else $error("manual integration did not start");

    property p_manual_stop;
        @(posedge core_clk_i) disable iff (!nrst_i)
        q.state == integ_sync_pkg::ST_MANUAL && q.power && !q.adc_en
            |=> conv_done_o && !integrating_o;
    endproperty
    a_manual_stop: assert property (p_manual_stop) // [RL2]
        else $error("manual integration did not stop on enable clear");

    property p_one_shot;
        @(posedge core_clk_i) disable iff (!nrst_i)
        q.state == integ_sync_pkg::ST_WAIT_SYNC && run_ok && rise
            && mode == integ_sync_pkg::INTEG_ONE_SHOT
            |=> q.state == integ_sync_pkg::ST_TIMED && integrating_o;
    endproperty
    a_one_shot: assert property (p_one_shot) // [RL4]
        else $error("sync rise did not start timed integration");

    property p_timed_end;
        @(posedge core_clk_i) disable iff (!nrst_i)
        q.state == integ_sync_pkg::ST_TIMED && run_ok
            && q.tmr == period_last |=> conv_done_o ##1 !conv_done_o;
    endproperty
    a_timed_end: assert property (p_timed_end) // [RL5]
        else $error("timed integration did not end at its period");

    property p_locked;
        @(posedge core_clk_i) disable iff (!nrst_i)
        q.lock && q.adc_en && q.state == integ_sync_pkg::ST_IDLE
            |=> q.state == integ_sync_pkg::ST_IDLE && !integrating_o;
    endproperty
    a_locked: assert property (p_locked) // [RL7]
        else $error("integration restarted without enable toggle");

    property p_rise_stop;
        @(posedge core_clk_i) disable iff (!nrst_i)
        q.state == integ_sync_pkg::ST_PULSE && run_ok && rise
            && q.timing[`TIM_EDGE_BIT] && q.edge_cnt == integ_time_or_pulse_count
            |=> conv_done_o && q.lock;
    endproperty
    a_rise_stop: assert property (p_rise_stop) // [RL8]
        else $error("pulse count did not end on rising edge");

    property p_gate_high;
        @(posedge core_clk_i) disable iff (!nrst_i)
        q.state == integ_sync_pkg::ST_PULSE && run_ok && fall
            |=> !integrating_o;
    endproperty
    a_gate_high: assert property (p_gate_high) // [RL10]
        else $error("integrating while sync is low");

    property p_every_conv;
        @(posedge core_clk_i) disable iff (!nrst_i)
        conv_done_o && persist == 3'h0 && !reg_wr_i
            && (style == integ_sync_pkg::IRQ_LEVEL
            || style == integ_sync_pkg::IRQ_ALERT) |=> irq_oe_o;
    endproperty
    a_every_conv: assert property (p_every_conv) // [RL20]
        else $error("end-of-conversion interrupt missing");

    property p_level_hold;
        @(posedge core_clk_i) disable iff (!nrst_i)
        q.pending && style == integ_sync_pkg::IRQ_LEVEL && !clr_level
            && !reg_wr_i |=> irq_oe_o;
    endproperty
    a_level_hold: assert property (p_level_hold) // [RL17]
        else $error("level interrupt released without clear");

    property p_alert_clear;
        @(posedge core_clk_i) disable iff (!nrst_i)
        q.pending && style == integ_sync_pkg::IRQ_ALERT && alert_resp_i
            && !q.eval && !reg_wr_i |=> alert_ack_o && !irq_oe_o;
    endproperty
    a_alert_clear: assert property (p_alert_clear) // [RL19]
        else $error("alert response not answered");

    property p_disabled;
        @(posedge core_clk_i) disable iff (!nrst_i)
        q.irq_ctrl == 8'h00 && !reg_wr_i |=> !irq_oe_o;
    endproperty
    a_disabled: assert property (p_disabled) // [RL13]
        else $error("interrupt active while disabled");

    c_free_conv: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
        conv_done_o && mode == integ_sync_pkg::INTEG_FREE);
    c_pulse_conv: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
        conv_done_o && mode == integ_sync_pkg::INTEG_PULSES);
    c_level_clear: cover property (@(posedge core_clk_i)
        disable iff (!nrst_i) $fell(irq_oe_o) && clr_level);

endmodule
`default_nettype wire

/* verification/sync_pulse_model.sv */
// Sync pulse source on its own link clock.
// Assumes the sink samples sync_pin_o on sync_clk_o.
`timescale 1ns/100ps
`default_nettype none
module sync_pulse_model (
    output var logic sync_clk_o,
    output var logic sync_pin_o
);
    // Runs through reset, then only while pulses are sent
    logic run = 1'b1;
    initial
    begin
        sync_clk_o = 1'b0;
        sync_pin_o = 1'b0;
        #3.3;
        forever
        begin
            #15;
            sync_clk_o = run ? ~sync_clk_o : sync_clk_o;
        end
    end
    initial #1000 run = 1'b0;
    task automatic pulses(input int n);
        run = 1'b1;
        repeat (n)
        begin
            @(posedge sync_clk_o) sync_pin_o <= 1'b1;
            repeat (1700) @(posedge sync_clk_o);
            sync_pin_o <= 1'b0;
            repeat (200) @(posedge sync_clk_o);
        end
        run = 1'b0;
    endtask
endmodule
`default_nettype wire

/* verification/integ_sync_irq_ctrl_tb.sv */
// Self-checking bench of the integration and interrupt controller.
// Assumes shortened integration counts and the sync source model.
`timescale 1ns/100ps
`default_nettype none
module integ_sync_irq_ctrl_tb;
    typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] e;} row_type;
    row_type rows [8] = '{'{5'h01, 8'h75, 8'h75}, '{5'h02, 8'h23, 8'h23},
        '{5'h03, 8'h02, 8'h02}, '{5'h08, 8'hA5, 8'hA5},
        '{5'h09, 8'h5A, 8'h5A}, '{5'h0B, 8'hC3, 8'hC3},
        '{5'h10, 8'hFF, 8'h00}, '{5'h1F, 8'h77, 8'h00}};
    int per [3] = '{20, 40, 80};
    int err_count = 0;
    int cmp_count = 0;
    int done_cnt = 0;
    int integ_cyc = 0;
    int d;
    logic core_clk_i, nrst_i, reg_wr_i, reg_rd_i, cmd_wr_i, alert_resp_i;
    logic sync_clk, sync_pin, integrating_o, conv_done_o, alert_ack_o;
    logic irq_o, irq_oe_o;
    logic [4:0] reg_addr_i;
    logic [7:0] reg_wdata_i, cmd_byte_i, reg_rdata_o;
    logic [63:0] adc_data_i;
    integ_sync_irq_ctrl #(.SHORT_CYC(20), .MID_CYC(40), .LONG_CYC(80))
        integ_sync_irq_ctrl_inst (.core_clk_i, .nrst_i,
        .sync_clk_i(sync_clk), .sync_pin_i(sync_pin), .reg_wr_i, .reg_rd_i,
        .reg_addr_i, .reg_wdata_i, .cmd_wr_i, .cmd_byte_i, .alert_resp_i,
        .adc_data_i, .reg_rdata_o, .integrating_o, .conv_done_o,
        .alert_ack_o, .irq_o, .irq_oe_o);
    sync_pulse_model sync_pulse_model_inst (.sync_clk_o(sync_clk),
        .sync_pin_o(sync_pin));
    initial
    begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i)
    begin
        done_cnt <= done_cnt + conv_done_o;
        integ_cyc <= integ_cyc + integrating_o;
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e)
        begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic near(input int v, input int e);
        chk(v >= e - 3 && v <= e + 3, 1'b1);
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        reg_addr_i = a;
        reg_wdata_i = v;
        reg_wr_i = 1'b1;
        tick(1);
        reg_wr_i = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        tick(1);
        reg_rd_i = 1'b0;
        tick(1);
        chk(reg_rdata_o, e);
    endtask
    task automatic cmd(input logic [7:0] c);
        cmd_byte_i = c;
        cmd_wr_i = 1'b1;
        tick(1);
        cmd_wr_i = 1'b0;
    endtask
    task automatic burst(input int n);
        sync_pulse_model_inst.pulses(n);
        tick(1);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Bounded wait for the next completed conversion
    task automatic wait_done();
        int k = done_cnt;
        for (int i = 0; i < 200 && done_cnt == k; i++)
            tick(1);
        if (done_cnt == k)
        begin
            err_count++;
            $display("timeout waiting for conversion at %0t", $time);
            summarize();
        end
    endtask
    initial
    begin
        {nrst_i, reg_wr_i, reg_rd_i, cmd_wr_i, alert_resp_i} = '0;
        {reg_addr_i, reg_wdata_i, cmd_byte_i} = '0;
        adc_data_i = 64'h0400_0300_0800_0200;
        tick(16);
        nrst_i = 1'b1;
        tick(1);
        chk({irq_o, irq_oe_o}, 2'h0);
        rd(5'h01, 8'h00);
        rd(5'h02, 8'h00);
        rd(5'h03, 8'h00);
        $display("test reset finished");
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        $display("test registers finished");
        wr(5'h02, 8'h00);
        wr(5'h00, 8'h03);
        for (int p = 0; p < 3; p++)
        begin
            wr(5'h01, 8'(p));
            wait_done();
            integ_cyc = 0;
            wait_done();
            chk(integ_cyc, per[p]);
        end
        for (int k = 0; k < 8; k++)
            rd(5'(16 + k), adc_data_i[8 * k +: 8]);
        $display("test free run finished");
        wr(5'h01, 8'h00);
        wr(5'h08, 8'h00);
        wr(5'h09, 8'h01);
        wr(5'h0A, 8'h00);
        wr(5'h0B, 8'h10);
        wr(5'h03, 8'h01);
        wr(5'h02, 8'h12);
        wait_done();
        wait_done();
        adc_data_i[31:16] = 16'h2000;
        wait_done();
        tick(1);
        chk(irq_oe_o, 1'b0);
        wait_done();
        tick(1);
        chk(irq_oe_o, 1'b1);
        cmd(8'h60);
        chk(irq_oe_o, 1'b0);
        wr(5'h02, 8'h22);
        wait_done();
        tick(1);
        cmd(8'h60);
        chk(irq_oe_o, 1'b1);
        alert_resp_i = 1'b1;
        tick(1);
        alert_resp_i = 1'b0;
        chk({alert_ack_o, irq_oe_o}, 2'h2);
        adc_data_i[31:16] = 16'h0800;
        wr(5'h02, 8'h10);
        wait_done();
        tick(1);
        cmd(8'h60);
        wait_done();
        tick(1);
        chk(irq_oe_o, 1'b1);
        wr(5'h02, 8'h00);
        chk(irq_oe_o, 1'b0);
        wr(5'h02, 8'h30);
        chk(irq_oe_o, 1'b1);
        wr(5'h02, 8'h00);
        wait_done();
        tick(1);
        chk(irq_oe_o, 1'b0);
        $display("test interrupt finished");
        wr(5'h00, 8'h01);
        wr(5'h01, 8'h10);
        wr(5'h00, 8'h03);
        tick(10);
        chk(integrating_o, 1'b1);
        d = done_cnt;
        wr(5'h00, 8'h01);
        tick(2);
        chk({integrating_o, 8'(done_cnt - d)}, 9'h001);
        rd(5'h11, adc_data_i[15:8]);
        $display("test manual finished");
        wr(5'h01, 8'h21);
        wr(5'h00, 8'h03);
        for (int r = 0; r < 3; r++)
        begin
            if (r == 2)
            begin
                wr(5'h00, 8'h01);
                wr(5'h00, 8'h03);
            end
            integ_cyc = 0;
            d = done_cnt;
            burst(1);
            chk(integ_cyc, r == 1 ? 0 : 40);
            chk(done_cnt - d, r == 1 ? 0 : 1);
        end
        $display("test one shot finished");
        wr(5'h00, 8'h01);
        wr(5'h01, 8'h30);
        wr(5'h00, 8'h03);
        integ_cyc = 0;
        d = done_cnt;
        burst(1);
        near(integ_cyc, 2550);
        chk(done_cnt - d, 1);
        wr(5'h00, 8'h01);
        wr(5'h01, 8'h71);
        wr(5'h00, 8'h03);
        integ_cyc = 0;
        d = done_cnt;
        burst(2);
        chk(done_cnt - d, 0);
        burst(1);
        chk(done_cnt - d, 1);
        near(integ_cyc, 5100);
        $display("test pulse count finished");
        summarize();
    end
endmodule
`default_nettype wire
